// ==== design/ispt_pkg.sv ====
package ispt_pkg;

  // bus address: five fixed upper bits, two selectable low bits
  localparam logic [4:0] DEV_ADDR_HI = 5'h0a;
  localparam logic [7:0] FIFO_DATA_ADDR = 8'h05;

  // link timing
  localparam int CORE_CLK_MHZ = 125;
  localparam int LINK_MAX_KHZ = 5000;
  localparam int T_LOW_MIN_NS = 100;
  localparam int SYNC_LAG_NS = 24;
  localparam int SETUP_MARGIN_NS = 28;
  // drive window: low time less sync lag and margin, rounded down
  localparam int DRIVE_WINDOW_NS = T_LOW_MIN_NS - SYNC_LAG_NS - SETUP_MARGIN_NS;
  localparam int DRIVE_CYCLES_INT = (DRIVE_WINDOW_NS * CORE_CLK_MHZ) / 1000;
  localparam logic [3:0] DRIVE_CYCLES =
    (DRIVE_CYCLES_INT < 1) ? 4'h1 : 4'(DRIVE_CYCLES_INT);

  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  localparam int BUF_WIDTH = 16;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEV_ADDR = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_REG_ADDR = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WR_DATA = 4'b0101,
    ST_WR_ACK = 4'b0110,
    ST_RD_DATA = 4'b0111,
    ST_RD_ACK = 4'b1000,
    ST_IGNORE = 4'b1001
  } ispt_state_t;

endpackage

// ==== design/ispt_buffer.sv ====
`timescale 1ns/1ps
module ispt_buffer
  import ispt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  input wire logic [BUF_WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [BUF_WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  logic [BUF_WIDTH-1:0] mem_reg [BUF_DEPTH];
  logic wr_idx_reg;
  logic rd_idx_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  logic [1:0] count_next;
  logic rd_idx_next;
  logic [BUF_WIDTH-1:0] head_next;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
  assign rd_idx_next = pop ? ~rd_idx_reg : rd_idx_reg;
  // head is the arriving word once nothing older is left
  assign head_next = (count_reg == {1'b0, pop}) ? in_data_in : mem_reg[rd_idx_next];

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_idx_reg] <= in_data_in;
    end
  end

  // registered head so the word leaves straight from a flop
  always_ff @(posedge core_clk_in) begin
    out_data_out <= head_next;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_idx_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
      count_reg <= 2'h0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_idx_reg <= ~wr_idx_reg;
      end
      if (pop) begin
        rd_idx_reg <= ~rd_idx_reg;
      end
      count_reg <= count_next;
      in_ready_out <= (count_next != 2'(BUF_DEPTH));
      out_valid_out <= (count_next != 2'h0);
    end
  end

endmodule // ispt_buffer

// ==== design/ispt_link_slave.sv ====
`timescale 1ns/1ps
module ispt_link_slave
  import ispt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  output logic sda_out_out,
  output logic sda_oe_out,
  input wire logic adr_pin_in,
  input wire logic nv_addr_sel_in,
  input wire logic [1:0] nv_addr_in,
  output logic wr_valid_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  input wire logic wr_ready_in,
  output logic rd_req_out,
  output logic [7:0] rd_addr_out,
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in
);

  function automatic logic [7:0] ptr_step(input logic [7:0] ptr);
    ptr_step = (ptr == FIFO_DATA_ADDR) ? ptr : ptr + 8'h01;
  endfunction

  // ---------- link clock domain: sample data on each rising clock ----------
  logic [7:0] link_shift_reg;
  logic link_rise_tgl_reg;

  always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      link_shift_reg <= BYTE_RESET;
    end else begin
      link_shift_reg <= {link_shift_reg[6:0], sda_in};
    end
  end

  always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      link_rise_tgl_reg <= 1'b0;
    end else begin
      link_rise_tgl_reg <= ~link_rise_tgl_reg;
    end
  end

  // ---------- crossings into the core clock ----------
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_prev_reg;
  logic adr_meta_reg;
  logic adr_sync_reg;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
      adr_meta_reg <= 1'b0;
      adr_sync_reg <= 1'b0;
    end else begin
      scl_meta_reg <= scl_clk_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      tgl_meta_reg <= link_rise_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_prev_reg <= tgl_sync_reg;
      adr_meta_reg <= adr_pin_in;
      adr_sync_reg <= adr_meta_reg;
    end
  end

  logic rise_evt;
  logic fall_evt;
  logic start_evt;
  logic stop_evt;

  // shift word is stable for a full clock period after the toggle moves
  assign rise_evt = tgl_sync_reg ^ tgl_prev_reg;
  assign fall_evt = scl_prev_reg & ~scl_sync_reg;
  assign start_evt = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_evt = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  // ---------- own address ----------
  logic [6:0] own_addr_reg;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      own_addr_reg <= {DEV_ADDR_HI, 2'h0};
    end else if (nv_addr_sel_in) begin
      own_addr_reg <= {DEV_ADDR_HI, nv_addr_in};
    end else begin
      own_addr_reg <= {DEV_ADDR_HI, 1'b0, adr_sync_reg};
    end
  end

  // ---------- protocol engine ----------
  ispt_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic ack_reg;
  logic [7:0] tx_reg;
  logic buf_in_valid_reg;
  logic [15:0] buf_in_data_reg;
  logic buf_in_ready;
  logic [15:0] buf_out_data;
  logic [7:0] rx_byte;
  logic byte_done;
  logic ack_rise;
  logic addr_match;
  logic tx_dir_reg;

  assign rx_byte = link_shift_reg;
  assign byte_done = rise_evt & (bit_cnt_reg == BIT_LAST_DATA);
  assign ack_rise = rise_evt & (bit_cnt_reg == BIT_ACK_SLOT);
  assign addr_match = (rx_byte[7:1] == own_addr_reg);

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt_reg <= BIT_CNT_RESET;
    end else if (start_evt || stop_evt) begin
      bit_cnt_reg <= BIT_CNT_RESET;
    end else if (ack_rise) begin
      bit_cnt_reg <= BIT_CNT_RESET;
    end else if (rise_evt) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
    end else if (start_evt) begin
      state_reg <= ST_DEV_ADDR;
      ack_reg <= 1'b0;
    end else if (stop_evt) begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
    end else if (byte_done) begin
      case (state_reg)
        ST_DEV_ADDR: begin
          state_reg <= addr_match ? ST_DEV_ACK : ST_IGNORE;
          ack_reg <= addr_match;
        end
        ST_REG_ADDR: begin
          state_reg <= ST_REG_ACK;
          ack_reg <= 1'b1;
        end
        ST_WR_DATA: begin
          state_reg <= ST_WR_ACK;
          ack_reg <= buf_in_ready;
        end
        ST_RD_DATA: begin
          state_reg <= ST_RD_ACK;
          ack_reg <= 1'b0;
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end else if (ack_rise) begin
      case (state_reg)
        ST_DEV_ACK: begin
          state_reg <= tx_dir_reg ? ST_RD_DATA : ST_REG_ADDR;
        end
        ST_REG_ACK: begin
          state_reg <= ST_WR_DATA;
        end
        ST_WR_ACK: begin
          state_reg <= ack_reg ? ST_WR_DATA : ST_IGNORE;
        end
        ST_RD_ACK: begin
          state_reg <= rx_byte[0] ? ST_IGNORE : ST_RD_DATA;
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
      ack_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_dir_reg <= 1'b0;
    end else if (byte_done && state_reg == ST_DEV_ADDR) begin
      tx_dir_reg <= rx_byte[0];
    end
  end

  // pointer survives between frames so a read follows the pointer write
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ptr_reg <= PTR_RESET;
    end else if (byte_done && state_reg == ST_REG_ADDR) begin
      ptr_reg <= rx_byte;
    end else if (byte_done && state_reg == ST_WR_DATA && buf_in_ready) begin
      ptr_reg <= ptr_step(ptr_reg);
    end else if (ack_rise && state_reg == ST_RD_ACK) begin
      ptr_reg <= ptr_step(ptr_reg);
    end
  end

  // fetch only when a byte will surely be sent, so fifo entries are not lost
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_req_out <= 1'b0;
      rd_addr_out <= PTR_RESET;
    end else if (byte_done && state_reg == ST_DEV_ADDR && addr_match && rx_byte[0]) begin
      rd_req_out <= 1'b1;
      rd_addr_out <= ptr_reg;
    end else if (ack_rise && state_reg == ST_RD_ACK && !rx_byte[0]) begin
      rd_req_out <= 1'b1;
      rd_addr_out <= ptr_step(ptr_reg);
    end else begin
      rd_req_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_reg <= BYTE_RESET;
    end else if (rd_valid_in) begin
      tx_reg <= rd_data_in;
    end
  end

  // written bytes enter the buffer with their target address
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buf_in_valid_reg <= 1'b0;
      buf_in_data_reg <= 16'h0000;
    end else if (byte_done && state_reg == ST_WR_DATA && buf_in_ready) begin
      buf_in_valid_reg <= 1'b1;
      buf_in_data_reg <= {ptr_reg, rx_byte};
    end else begin
      buf_in_valid_reg <= 1'b0;
    end
  end

  logic buf_ready_raw;

  // no byte taken while a word is still in flight, even with a slot free
  assign buf_in_ready = buf_ready_raw & ~buf_in_valid_reg;

  ispt_buffer u_buffer (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(buf_in_valid_reg),
    .in_data_in(buf_in_data_reg),
    .in_ready_out(buf_ready_raw),
    .out_valid_out(wr_valid_out),
    .out_data_out(buf_out_data),
    .out_ready_in(wr_ready_in)
  );

  assign wr_addr_out = buf_out_data[15:8];
  assign wr_data_out = buf_out_data[7:0];

  // ---------- data line driver ----------
  logic [3:0] drive_cnt_reg;
  logic drive_now;
  logic drive_val;

  always_comb begin
    drive_now = 1'b0;
    drive_val = 1'b1;
    if ((state_reg == ST_DEV_ACK || state_reg == ST_REG_ACK || state_reg == ST_WR_ACK)
        && bit_cnt_reg == BIT_ACK_SLOT) begin
      // refusal is driven high: the keeper would otherwise show the last bit
      drive_now = 1'b1;
      drive_val = ~ack_reg;
    end else if (state_reg == ST_RD_DATA && bit_cnt_reg <= BIT_LAST_DATA) begin
      drive_now = 1'b1;
      drive_val = tx_reg[3'(BIT_LAST_DATA - bit_cnt_reg)];
    end
  end

  // drive right after a falling clock, release well before the rise
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_oe_out <= 1'b0;
      drive_cnt_reg <= 4'h0;
    end else if (start_evt || stop_evt) begin
      sda_oe_out <= 1'b0;
      drive_cnt_reg <= 4'h0;
    end else if (fall_evt && drive_now) begin
      sda_oe_out <= 1'b1;
      drive_cnt_reg <= DRIVE_CYCLES;
    end else if (drive_cnt_reg > 4'h1) begin
      drive_cnt_reg <= drive_cnt_reg - 4'h1;
    end else begin
      sda_oe_out <= 1'b0;
      drive_cnt_reg <= 4'h0;
    end
  end

  // keeper: hold own level, follow the master's level otherwise
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_out_out <= 1'b1;
    end else if (fall_evt && drive_now) begin
      sda_out_out <= drive_val;
    end else if (!sda_oe_out) begin
      sda_out_out <= sda_sync_reg;
    end
  end

endmodule // ispt_link_slave

// ==== verif/ispt_link_slave_properties.sv ====
`timescale 1ns/1ps
module ispt_link_slave_properties (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_clk_in,
  input wire logic sda_out_out,
  input wire logic sda_oe_out,
  input wire logic wr_valid_out,
  input wire logic [7:0] wr_addr_out,
  input wire logic [7:0] wr_data_out,
  input wire logic wr_ready_in,
  input wire logic rd_req_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  drive_low_only_a:
    assert property (sda_oe_out |-> !scl_clk_in) else $error("sda driven in clock high");
  oe_burst_a:
    assert property ($rose(sda_oe_out) |-> sda_oe_out [*6] ##1 !sda_oe_out)
    else $error("drive burst length wrong");
  drive_after_fall_a:
    assert property ($rose(sda_oe_out) |-> !$past(scl_clk_in, 2)) else $error("drive too early");
  reset_quiet_a:
    assert property (disable iff (1'b0) sys_rst_in |-> !sda_oe_out && !wr_valid_out && !rd_req_out)
    else $error("outputs active in reset");
  rd_pulse_a:
    assert property (rd_req_out |=> !rd_req_out) else $error("fetch not a pulse");
  wr_hold_a:
    assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_addr_out)
      && $stable(wr_data_out)) else $error("write word lost");
  keeper_hold_a:
    assert property ($fell(sda_oe_out) |-> sda_out_out == $past(sda_out_out))
    else $error("keeper lost level");
  ack_after_word_a:
    assert property ($rose(wr_valid_out) |-> ##[1:20] sda_oe_out && !sda_out_out)
    else $error("stored byte not acked");

  cover property (wr_valid_out && wr_ready_in);
  cover property (wr_valid_out && !wr_ready_in);
  cover property (rd_req_out);
endmodule // ispt_link_slave_properties

bind ispt_link_slave ispt_link_slave_properties chk_u (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .scl_clk_in(scl_clk_in), .sda_out_out(sda_out_out),
  .sda_oe_out(sda_oe_out), .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out),
  .wr_data_out(wr_data_out), .wr_ready_in(wr_ready_in), .rd_req_out(rd_req_out));

// ==== verif/ispt_master_model.sv ====
`timescale 1ns/1ps
module ispt_master_model (
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_drv_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
    sda_oe_out = 1'b1;
  end

  task automatic start_cond();
    #10 sda_oe_out = 1'b1;
    sda_drv_out = 1'b1;
    #90 scl_out = 1'b1;
    #80 sda_drv_out = 1'b0;
    #80 scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #10 sda_oe_out = 1'b1;
    sda_drv_out = 1'b0;
    #90 scl_out = 1'b1;
    #80 sda_drv_out = 1'b1;
    #200;
  endtask

  // one clock period; the line is released for the high phase
  task automatic bit_io(input logic d, input logic drv, output logic s);
    #10 sda_oe_out = drv;
    sda_drv_out = d;
    #90 sda_oe_out = 1'b0;
    scl_out = 1'b1;
    #30 s = sda_line_in;
    #30 scl_out = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], 1'b1, s);
    end
    bit_io(1'b1, 1'b0, ack);
  endtask

  task automatic get_byte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 1'b0, s);
      b[i] = s;
    end
    bit_io(nack, 1'b1, s);
  endtask
endmodule // ispt_master_model

// ==== verif/test_i2c_slave_register_port.sv ====
`timescale 1ns/1ps
module test_i2c_slave_register_port
  import ispt_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b0;
  logic adr_pin = 1'b0;
  logic nv_sel = 1'b0;
  logic [1:0] nv_addr = 2'b11;
  logic wr_ready = 1'b1;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] fifo_cnt = 8'h30;
  logic scl, sda_line, m_drv, m_oe, sda_out, sda_oe, wr_valid, rd_req;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [15:0] words[$];
  int num_errors = 0;
  int n_compared = 0;
  // address bytes for the default strap, low bits 00
  localparam logic [7:0] DEV_WR = {DEV_ADDR_HI, 3'h0};
  localparam logic [7:0] DEV_RD = {DEV_ADDR_HI, 3'h1};

  always #4 core_clk_in = ~core_clk_in;
  // released by both: the device keeper level
  assign sda_line = (sda_oe || !m_oe) ? sda_out : m_drv;

  ispt_master_model mst_u (.sda_line_in(sda_line), .scl_out(scl), .sda_drv_out(m_drv),
    .sda_oe_out(m_oe));
  ispt_link_slave dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_clk_in(scl),
    .sda_in(sda_line), .sda_out_out(sda_out), .sda_oe_out(sda_oe), .adr_pin_in(adr_pin),
    .nv_addr_sel_in(nv_sel), .nv_addr_in(nv_addr), .wr_valid_out(wr_valid),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_ready_in(wr_ready),
    .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_valid_in(rd_valid), .rd_data_in(rd_data));

  always @(posedge core_clk_in) begin
    rd_valid <= rd_req;
    rd_data <= (rd_addr == FIFO_DATA_ADDR) ? fifo_cnt : rd_addr ^ 8'h5a;
    if (rd_req && rd_addr == FIFO_DATA_ADDR) begin
      fifo_cnt <= fifo_cnt + 8'h01;
    end
    if (wr_valid && wr_ready) begin
      words.push_back({wr_addr, wr_data});
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_frame(input logic [7:0] dev, input logic [7:0] ra, input int n,
      output logic [7:0] acks);
    logic a;
    acks = 8'h00;
    mst_u.start_cond();
    mst_u.put_byte(dev, a);
    acks[0] = a;
    mst_u.put_byte(ra, a);
    acks[1] = a;
    for (int i = 0; i < n; i++) begin
      mst_u.put_byte(8'hc0 + 8'(i), a);
      acks[i + 2] = a;
    end
  endtask

  task automatic chk_words(input logic [7:0] ra, input logic inc, input int n);
    logic [15:0] w;
    repeat (20) @(posedge core_clk_in);
    chk8(8'(words.size()), 8'(n));
    for (int i = 0; i < n && words.size() > 0; i++) begin
      w = words.pop_front();
      chk8(w[15:8], inc ? ra + 8'(i) : ra);
      chk8(w[7:0], 8'hc0 + 8'(i));
    end
    words.delete();
  endtask

  task automatic rd_frame(input logic [7:0] ra, input logic fifo);
    logic [7:0] acks, b, f0;
    f0 = fifo_cnt;
    wr_frame(DEV_WR, ra, 0, acks);
    mst_u.start_cond();
    mst_u.put_byte(DEV_RD, acks[2]);
    chk8(acks, 8'h00);
    for (int i = 0; i < 3; i++) begin
      mst_u.get_byte(b, i == 2);
      chk8(b, fifo ? f0 + 8'(i) : (ra + 8'(i)) ^ 8'h5a);
    end
    mst_u.stop_cond();
  endtask

  task automatic t_write();
    logic [7:0] acks;
    wr_frame(DEV_WR, 8'h10, 3, acks);
    mst_u.stop_cond();
    chk8(acks, 8'h00);
    chk_words(8'h10, 1'b1, 3);
    wr_frame(DEV_WR, FIFO_DATA_ADDR, 3, acks);
    mst_u.stop_cond();
    chk_words(FIFO_DATA_ADDR, 1'b0, 3);
    $display("write test done");
  endtask

  task automatic t_read();
    rd_frame(8'h20, 1'b0);
    rd_frame(FIFO_DATA_ADDR, 1'b1);
    $display("read test done");
  endtask

  task automatic t_address();
    logic [7:0] acks;
    logic [7:0] dev[4] = '{8'h52, 8'h56, 8'h52, 8'h56};
    logic [3:0] pin = 4'b1100;
    logic [3:0] sel = 4'b0010;
    logic [3:0] hit = 4'b0110;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      adr_pin <= pin[i];
      nv_sel <= sel[i];
      repeat (4) @(posedge core_clk_in);
      wr_frame(dev[i], 8'h31, 1, acks);
      mst_u.stop_cond();
      // ignored slots read the keeper, i.e. the last bit the master sent
      chk8(acks, hit[i] ? 8'h00 : 8'h02);
      chk_words(8'h31, 1'b1, hit[i] ? 1 : 0);
    end
    @(posedge core_clk_in);
    adr_pin <= 1'b0;
    nv_sel <= 1'b0;
    $display("address test done");
  endtask

  task automatic t_full();
    logic [7:0] acks;
    @(posedge core_clk_in);
    wr_ready <= 1'b0;
    wr_frame(DEV_WR, 8'h40, 4, acks);
    mst_u.stop_cond();
    // third byte refused high, fourth ignored and read from the keeper
    chk8(acks, 8'h30);
    @(posedge core_clk_in);
    wr_ready <= 1'b1;
    chk_words(8'h40, 1'b1, 2);
    $display("full test done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    // a real edge at time zero so both clock domains see the reset
    sys_rst_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    t_write();
    t_read();
    t_address();
    t_full();
    report_and_stop();
  end

  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule // test_i2c_slave_register_port
